/* File: verilog/tcd_pkg.sv */
// tcd_pkg: register map, field positions, timing constants and types of the tap detector
package tcd_pkg;

  // register offsets as printed
  localparam logic [7:0] ADDR_IRQ_ROUTE     = 8'h22;
  localparam logic [7:0] ADDR_TAP_CONFIG    = 8'h38;
  localparam logic [7:0] ADDR_TAP_SOURCE    = 8'h39;
  localparam logic [7:0] ADDR_THRESHOLD_XY  = 8'h3B;
  localparam logic [7:0] ADDR_THRESHOLD_Z   = 8'h3C;
  localparam logic [7:0] ADDR_MAX_DURATION  = 8'h3D;
  localparam logic [7:0] ADDR_LATENCY       = 8'h3E;
  localparam logic [7:0] ADDR_WINDOW        = 8'h3F;

  // values after reset
  localparam logic [7:0] RST_IRQ_ROUTE      = 8'h00;
  localparam logic [7:0] RST_TAP_CONFIG     = 8'h00;
  localparam logic [6:0] RST_TAP_SOURCE     = 7'h00;
  localparam logic [7:0] RST_THRESHOLD_XY   = 8'h00;
  localparam logic [3:0] RST_THRESHOLD_Z    = 4'h0;
  localparam logic [7:0] RST_MAX_DURATION   = 8'h00;
  localparam logic [7:0] RST_LATENCY        = 8'h00;
  localparam logic [7:0] RST_WINDOW         = 8'h00;

  // field positions
  localparam int         CFG_LATCH_BIT      = 6;
  localparam logic [7:0] CFG_WRITE_MASK     = 8'h7F;
  localparam int         SRC_ACTIVE_BIT     = 6;
  localparam int         ROUTE_POLARITY_BIT = 7;
  localparam int         ROUTE_OPEN_DRAIN   = 6;
  localparam int         ROUTE_B_LSB        = 3;
  localparam int         ROUTE_A_LSB        = 0;
  localparam logic [2:0] ROUTE_SEL_TAP      = 3'h7;
  localparam int         THR_X_LSB          = 0;
  localparam int         THR_Y_LSB          = 4;

  // time base: one tick every 0.5 ms
  localparam int         CLK_PERIOD_PS      = 5000;
  localparam int         TICK_PERIOD_PS     = 500000000;
  localparam int         TICK_CYCLES_DEF    = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int         TICKS_PER_MS       = 2;
  localparam int         CNT_W              = 10;

  // per-axis tap settings
  typedef struct packed {
    logic [3:0] threshold;
    logic [7:0] max_duration;
    logic [7:0] latency;
    logic [7:0] window;
    logic       en_single;
    logic       en_double;
  } tcd_axis_cfg_s;

  // per-axis recognised events, one-cycle pulses
  typedef struct packed {
    logic dbl;
    logic single;
  } tcd_axis_evt_s;

  typedef enum {
    ax_idle,
    ax_first,
    ax_latency,
    ax_window,
    ax_second,
    ax_wait_low
  } tcd_axis_state_e;

endpackage

/* File: verilog/tcd_axis.sv */
// tcd_axis: single and double tap recognition for one axis
module tcd_axis
  import tcd_pkg::*;
#(
  parameter int ACC_W = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             tick,
  input  wire tcd_axis_cfg_s    cfg,
  input  wire logic [ACC_W-1:0] acc_mag,
  output tcd_axis_evt_s         evt_r
);

  tcd_axis_state_e  state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  tcd_axis_evt_s    evt_nxt;
  logic [ACC_W-1:0] thr_level;
  logic             above;
  logic [CNT_W-1:0] dur_ticks;
  logic [CNT_W-1:0] lat_ticks;
  logic [CNT_W-1:0] win_ticks;
  logic [CNT_W-1:0] cnt_inc;

  // threshold in 0.5 g steps sits in the top four bits of the magnitude
  assign thr_level = {cfg.threshold, {(ACC_W-4){1'b0}}};
  assign above     = acc_mag > thr_level;
  assign dur_ticks = CNT_W'(cfg.max_duration);
  assign lat_ticks = CNT_W'(cfg.latency) * CNT_W'(TICKS_PER_MS);
  assign win_ticks = CNT_W'(cfg.window) * CNT_W'(TICKS_PER_MS);
  assign cnt_inc   = (tick && cnt_r != {CNT_W{1'b1}}) ? cnt_r + 1'b1 : cnt_r;

  // recognition sequence, timed by the 0.5 ms tick only
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_inc;
    evt_nxt   = '0;
    unique case (state_r)
      ax_idle: begin
        cnt_nxt = '0;
        if ((cfg.en_single || cfg.en_double) && above) begin
          state_nxt = ax_first;
        end
      end
      ax_first: begin
        if (!above && cnt_r < dur_ticks) begin
          evt_nxt.single = cfg.en_single;
          state_nxt      = cfg.en_double ? ax_latency : ax_idle;
          cnt_nxt        = '0;
        end else if (!above) begin
          state_nxt = ax_idle;
        end else if (cnt_r >= dur_ticks) begin
          state_nxt = ax_wait_low;                             // late fall gives nothing
        end
      end
      ax_latency: begin
        if (cnt_r >= lat_ticks) begin
          state_nxt = above ? ax_second : ax_window;
          cnt_nxt   = '0;
        end
      end
      ax_window: begin
        if (above) begin
          state_nxt = ax_second;
          cnt_nxt   = '0;
        end else if (cnt_r >= win_ticks) begin
          state_nxt = ax_idle;
        end
      end
      ax_second: begin
        if (!above && cnt_r < dur_ticks) begin
          evt_nxt.dbl = 1'b1;
          state_nxt   = ax_idle;
        end else if (!above) begin
          state_nxt = ax_idle;
        end else if (cnt_r >= dur_ticks) begin
          state_nxt = ax_wait_low;
        end
      end
      ax_wait_low: begin
        if (!above) begin
          state_nxt = ax_idle;
        end
      end
    endcase
    if (!(cfg.en_single || cfg.en_double)) begin
      state_nxt = ax_idle;
      evt_nxt   = '0;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ax_idle;
      cnt_r   <= '0;
      evt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      evt_r   <= evt_nxt;
    end
  end

endmodule

/* File: verilog/tcd_tap_detector.sv */
// tcd_tap_detector: three-axis tap detector with registers and two interrupt pins
//
// Operation
// - single tap: rise then fall within duration
// - unlatched interrupt held latency interval, minus up to one tick
// - latched interrupt held until source read
// - double tap needs second tap after first
// - second-tap detection suppressed during latency
// - second tap starts only inside window
// - second tap uses same duration criterion
// - tap interrupt routed to pin a/b
// - timing independent of output data rate
// - config: six enables plus latch bit, zero reset
// - per-axis enables select single, double, either
// - 4-bit threshold per axis, 0.5 g steps
// - 8-bit max duration in 0.5 ms steps
// - 8-bit latency in 1 ms steps
// - 8-bit window in 1 ms steps
module tcd_tap_detector
  import tcd_pkg::*;
#(
  parameter int ACC_W       = 8,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [2:0][ACC_W-1:0] acc_mag,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr_en,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_rd_en,
  output logic [7:0]                 reg_rdata_r,
  output logic                       irq_pin_a_r,
  output logic                       irq_pin_a_oe_r,
  output logic                       irq_pin_b_r,
  output logic                       irq_pin_b_oe_r
);

  // configuration registers
  logic [7:0]       route_r, route_nxt;
  logic [7:0]       tap_detect_config_r, tap_detect_config_nxt;
  logic [7:0]       tap_threshold_xy_r, tap_threshold_xy_nxt;
  logic [3:0]       tap_threshold_z_r, tap_threshold_z_nxt;
  logic [7:0]       tap_max_duration_r, tap_max_duration_nxt;
  logic [7:0]       tap_latency_r, tap_latency_nxt;
  logic [7:0]       tap_window_r, tap_window_nxt;
  logic [7:0]       rdata_nxt;

  // time base
  logic [31:0]      tick_cnt_r, tick_cnt_nxt;
  logic             tick_r, tick_nxt;

  // status and interrupt state
  logic [6:0]       tap_source_reg_r, tap_source_reg_nxt;
  logic             hold_r, hold_nxt;
  logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
  logic             pin_a_nxt, pin_a_oe_nxt;
  logic             pin_b_nxt, pin_b_oe_nxt;

  // per-axis wiring
  tcd_axis_cfg_s    axis_cfg [3];
  tcd_axis_evt_s    axis_evt [3];
  logic [5:0]       evt_bits;
  logic             any_evt;
  logic             latch_request_bit;
  logic             src_read;
  logic             wr_hit;
  logic             irq_level;
  logic [CNT_W-1:0] lat_ticks;

  assign latch_request_bit = tap_detect_config_r[CFG_LATCH_BIT];
  assign src_read          = reg_rd_en && reg_addr == ADDR_TAP_SOURCE;
  assign wr_hit            = reg_wr_en;
  assign lat_ticks         = CNT_W'(tap_latency_r) * CNT_W'(TICKS_PER_MS);

  // one detector per axis, each with its own threshold and enables
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      always_comb begin
        axis_cfg[g].threshold    = (g == 2) ? tap_threshold_z_r :
                                   tap_threshold_xy_r[g*4 +: 4];
        axis_cfg[g].max_duration = tap_max_duration_r;
        axis_cfg[g].latency      = tap_latency_r;
        axis_cfg[g].window       = tap_window_r;
        axis_cfg[g].en_single    = tap_detect_config_r[2*g];
        axis_cfg[g].en_double    = tap_detect_config_r[2*g+1];
      end
      tcd_axis #(
        .ACC_W (ACC_W)
      ) u_axis (
        .clk     (clk),
        .reset   (reset),
        .tick    (tick_r),
        .cfg     (axis_cfg[g]),
        .acc_mag (acc_mag[g]),
        .evt_r   (axis_evt[g])
      );
      assign evt_bits[2*g]   = axis_evt[g].single;
      assign evt_bits[2*g+1] = axis_evt[g].dbl;
    end
  endgenerate

  assign any_evt = |evt_bits;

  // fixed 0.5 ms tick, free of any sample rate
  always_comb begin
    tick_cnt_nxt = tick_cnt_r + 32'h1;
    tick_nxt     = 1'b0;
    if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // register writes and registered read data
  always_comb begin
    route_nxt             = route_r;
    tap_detect_config_nxt = tap_detect_config_r;
    tap_threshold_xy_nxt  = tap_threshold_xy_r;
    tap_threshold_z_nxt   = tap_threshold_z_r;
    tap_max_duration_nxt  = tap_max_duration_r;
    tap_latency_nxt       = tap_latency_r;
    tap_window_nxt        = tap_window_r;
    rdata_nxt             = reg_rdata_r;
    if (wr_hit) begin
      unique case (reg_addr)
        ADDR_IRQ_ROUTE:    route_nxt             = reg_wdata;
        ADDR_TAP_CONFIG:   tap_detect_config_nxt = reg_wdata & CFG_WRITE_MASK;
        ADDR_THRESHOLD_XY: tap_threshold_xy_nxt  = reg_wdata;
        ADDR_THRESHOLD_Z:  tap_threshold_z_nxt   = reg_wdata[3:0];
        ADDR_MAX_DURATION: tap_max_duration_nxt  = reg_wdata;
        ADDR_LATENCY:      tap_latency_nxt       = reg_wdata;
        ADDR_WINDOW:       tap_window_nxt        = reg_wdata;
        default:           ;                     // source and unmapped ignore writes
      endcase
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        ADDR_IRQ_ROUTE:    rdata_nxt = route_r;
        ADDR_TAP_CONFIG:   rdata_nxt = tap_detect_config_r;
        ADDR_TAP_SOURCE:   rdata_nxt = {1'b0, tap_source_reg_r};
        ADDR_THRESHOLD_XY: rdata_nxt = tap_threshold_xy_r;
        ADDR_THRESHOLD_Z:  rdata_nxt = {4'h0, tap_threshold_z_r};
        ADDR_MAX_DURATION: rdata_nxt = tap_max_duration_r;
        ADDR_LATENCY:      rdata_nxt = tap_latency_r;
        ADDR_WINDOW:       rdata_nxt = tap_window_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      route_r             <= RST_IRQ_ROUTE;
      tap_detect_config_r <= RST_TAP_CONFIG;
      tap_threshold_xy_r  <= RST_THRESHOLD_XY;
      tap_threshold_z_r   <= RST_THRESHOLD_Z;
      tap_max_duration_r  <= RST_MAX_DURATION;
      tap_latency_r       <= RST_LATENCY;
      tap_window_r        <= RST_WINDOW;
      reg_rdata_r         <= 8'h00;
    end else begin
      route_r             <= route_nxt;
      tap_detect_config_r <= tap_detect_config_nxt;
      tap_threshold_xy_r  <= tap_threshold_xy_nxt;
      tap_threshold_z_r   <= tap_threshold_z_nxt;
      tap_max_duration_r  <= tap_max_duration_nxt;
      tap_latency_r       <= tap_latency_nxt;
      tap_window_r        <= tap_window_nxt;
      reg_rdata_r         <= rdata_nxt;
    end
  end

  // source flags and hold timer; new events win over a clearing read
  always_comb begin
    tap_source_reg_nxt = tap_source_reg_r;
    hold_nxt           = hold_r;
    hold_cnt_nxt       = hold_cnt_r;
    if (src_read) begin
      tap_source_reg_nxt = '0;
    end
    if (hold_r) begin
      if (hold_cnt_r == '0) begin
        hold_nxt = 1'b0;
        if (!latch_request_bit) begin
          tap_source_reg_nxt = '0;
        end
      end else if (tick_r) begin
        hold_cnt_nxt = hold_cnt_r - 1'b1;
      end
    end
    if (any_evt) begin
      hold_nxt     = 1'b1;
      hold_cnt_nxt = lat_ticks;
      tap_source_reg_nxt[5:0] = (src_read ? 6'h00 : tap_source_reg_r[5:0]) | evt_bits;
    end
    tap_source_reg_nxt[SRC_ACTIVE_BIT] = |tap_source_reg_nxt[5:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tap_source_reg_r <= RST_TAP_SOURCE;
      hold_r           <= 1'b0;
      hold_cnt_r       <= '0;
    end else begin
      tap_source_reg_r <= tap_source_reg_nxt;
      hold_r           <= hold_nxt;
      hold_cnt_r       <= hold_cnt_nxt;
    end
  end

  // latched: flag stays until read; unlatched: the hold timer
  assign irq_level = latch_request_bit ? tap_source_reg_r[SRC_ACTIVE_BIT]
                                       : hold_r;

  // pin drivers: route select, polarity and push-pull or open drain
  always_comb begin
    logic act_a;
    logic act_b;
    logic lvl_a;
    logic lvl_b;
    act_a = irq_level && route_r[ROUTE_A_LSB +: 3] == ROUTE_SEL_TAP;
    act_b = irq_level && route_r[ROUTE_B_LSB +: 3] == ROUTE_SEL_TAP;
    lvl_a = act_a ^ route_r[ROUTE_POLARITY_BIT];
    lvl_b = act_b ^ route_r[ROUTE_POLARITY_BIT];
    if (route_r[ROUTE_OPEN_DRAIN]) begin
      pin_a_nxt    = 1'b0;
      pin_a_oe_nxt = !lvl_a;                                            // release for high
      pin_b_nxt    = 1'b0;
      pin_b_oe_nxt = !lvl_b;
    end else begin
      pin_a_nxt    = lvl_a;
      pin_a_oe_nxt = 1'b1;
      pin_b_nxt    = lvl_b;
      pin_b_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_pin_a_r    <= 1'b0;
      irq_pin_a_oe_r <= 1'b1;
      irq_pin_b_r    <= 1'b0;
      irq_pin_b_oe_r <= 1'b1;
    end else begin
      irq_pin_a_r    <= pin_a_nxt;
      irq_pin_a_oe_r <= pin_a_oe_nxt;
      irq_pin_b_r    <= pin_b_nxt;
      irq_pin_b_oe_r <= pin_b_oe_nxt;
    end
  end

endmodule

/* File: tb/tcd_checker.sv */
// tcd_checker: port-level assertions for the tap detector
module tcd_checker
  import tcd_pkg::*;
#(
  parameter int ACC_W       = 8,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic [2:0][ACC_W-1:0] acc_mag,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_wr_en,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_rd_en,
  input wire logic [7:0]            reg_rdata_r,
  input wire logic                  irq_pin_a_r,
  input wire logic                  irq_pin_a_oe_r,
  input wire logic                  irq_pin_b_r,
  input wire logic                  irq_pin_b_oe_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        latch_r;
  logic [7:0]  lat_r;
  logic [7:0]  route_r;
  logic [3:0]  rd_src_r;
  logic [15:0] hold_r;
  logic        act_a;

  // pin a active level after polarity; a released pin reads as pulled up
  assign act_a = (irq_pin_a_oe_r ? irq_pin_a_r : 1'b1) ^ route_r[ROUTE_POLARITY_BIT];

  // shadow of settings that pin timing depends on
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_r  <= 1'b0;
      lat_r    <= 8'h00;
      route_r  <= 8'h00;
      rd_src_r <= 4'h0;
      hold_r   <= 16'h0000;
    end else begin
      if (reg_wr_en && reg_addr == ADDR_TAP_CONFIG)
        latch_r <= reg_wdata[CFG_LATCH_BIT];
      if (reg_wr_en && reg_addr == ADDR_LATENCY)
        lat_r <= reg_wdata;
      if (reg_wr_en && reg_addr == ADDR_IRQ_ROUTE)
        route_r <= reg_wdata;
      rd_src_r <= {rd_src_r[2:0], reg_rd_en && reg_addr == ADDR_TAP_SOURCE};
      hold_r   <= act_a ? hold_r + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd_unmapped;
    reg_rd_en && reg_addr == 8'h00;
  endsequence
  sequence s_rd_idle;
    !reg_rd_en;
  endsequence

  property p_cfg_readback;
    logic [7:0] d;
    (reg_wr_en && !reg_rd_en && reg_addr == ADDR_TAP_CONFIG, d = reg_wdata) ##1 !reg_wr_en
      ##1 (reg_rd_en && !reg_wr_en && reg_addr == ADDR_TAP_CONFIG)
      |=> reg_rdata_r == (d & CFG_WRITE_MASK);
  endproperty

  a_reset_quiet: assert property (
    $fell(reset) |-> reg_rdata_r == 8'h00 && !irq_pin_a_r && !irq_pin_b_r)
    else $error("outputs not quiet after reset");
  a_rdata_hold: assert property (
    s_rd_idle |=> $stable(reg_rdata_r))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (
    s_rd_unmapped |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (p_cfg_readback)
    else $error("config read back wrong");
  a_route_gate: assert property (
    route_r[2:0] != ROUTE_SEL_TAP && $past(route_r[2:0]) != ROUTE_SEL_TAP
      && !route_r[7] && !$past(route_r[7]) |-> !irq_pin_a_r)
    else $error("pin a active without tap routing");
  a_oe_pushpull: assert property (
    !route_r[ROUTE_OPEN_DRAIN] && !$past(route_r[ROUTE_OPEN_DRAIN])
      |-> irq_pin_a_oe_r && irq_pin_b_oe_r)
    else $error("push-pull pin not driven");
  a_hold_bound: assert property (
    !latch_r && act_a |-> int'(hold_r) <= 2 * int'(lat_r) * TICK_CYCLES + 2)
    else $error("unlatched interrupt held too long");
  a_latch_release: assert property (
    latch_r && $fell(act_a) |-> rd_src_r != 4'h0)
    else $error("latched interrupt fell without source read");
endmodule

bind tcd_tap_detector tcd_checker #(.ACC_W(ACC_W), .TICK_CYCLES(TICK_CYCLES)) tcd_checker_inst (
  .clk(clk), .reset(reset), .acc_mag(acc_mag), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_r(reg_rdata_r),
  .irq_pin_a_r(irq_pin_a_r), .irq_pin_a_oe_r(irq_pin_a_oe_r), .irq_pin_b_r(irq_pin_b_r),
  .irq_pin_b_oe_r(irq_pin_b_oe_r));

/* File: tb/tcd_host_model.sv */
// tcd_host_model: host side that counts interrupt requests and times them
module tcd_host_model (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  irq_wire,
  output logic [7:0]  irq_cnt,
  output logic [15:0] last_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_r;
  logic        prev_r;

  // count each request and measure how long it stood
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_cnt  <= 8'h00;
      last_len <= 16'h0000;
      run_r    <= 16'h0000;
      prev_r   <= 1'b0;
    end else begin
      prev_r <= irq_wire;
      if (irq_wire)
        run_r <= run_r + 16'h0001;
      if (irq_wire && !prev_r)
        irq_cnt <= irq_cnt + 8'h01;
      if (!irq_wire && prev_r) begin
        last_len <= run_r;
        run_r    <= 16'h0000;
      end
    end
  end
endmodule

/* File: tb/tb.sv */
// tb: self-checking bench for the tap detector
module tb;
  import tcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 10;
  localparam logic [7:0] REGS [8] = '{ADDR_IRQ_ROUTE, ADDR_TAP_CONFIG, ADDR_TAP_SOURCE,
    ADDR_THRESHOLD_XY, ADDR_THRESHOLD_Z, ADDR_MAX_DURATION, ADDR_LATENCY, ADDR_WINDOW};
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  logic [2:0][7:0] acc_mag = '0;
  logic [7:0]      reg_addr = 8'h00;
  logic            reg_wr_en = 1'b0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_rd_en = 1'b0;
  logic [7:0]      reg_rdata_r;
  logic            irq_pin_a_r;
  logic            irq_pin_a_oe_r;
  logic            irq_pin_b_r;
  logic            irq_pin_b_oe_r;
  logic            pin_a_wire;
  logic [7:0]      irq_cnt;
  logic [15:0]     last_len;
  logic [7:0]      rdv;
  logic [7:0]      c0;
  int              error_cnt = 0;
  int              n_checks = 0;
  int              cyc = 0;

  always #2.5 clk = ~clk;
  // released pin is pulled up
  assign pin_a_wire = irq_pin_a_oe_r ? irq_pin_a_r : 1'b1;

  tcd_tap_detector #(.ACC_W(8), .TICK_CYCLES(TC)) tcd_tap_detector_inst (
    .clk(clk), .reset(reset), .acc_mag(acc_mag), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_r(reg_rdata_r),
    .irq_pin_a_r(irq_pin_a_r), .irq_pin_a_oe_r(irq_pin_a_oe_r), .irq_pin_b_r(irq_pin_b_r),
    .irq_pin_b_oe_r(irq_pin_b_oe_r));
  tcd_host_model tcd_host_model_inst (.clk(clk), .reset(reset), .irq_wire(pin_a_wire),
    .irq_cnt(irq_cnt), .last_len(last_len));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1 rdv = reg_rdata_r;
  endtask
  task automatic tap(input int i, input int n);
    @(posedge clk);
    acc_mag[i] <= 8'h40;
    repeat (n) @(posedge clk);
    acc_mag[i] <= 8'h00;
  endtask
  task automatic cnt_is(input string n, input logic [7:0] e);
    repeat (8) @(posedge clk);
    chk(n, {8'h00, e}, {8'h00, irq_cnt});
  endtask

  task automatic t_regs;
    foreach (REGS[k]) begin
      rd(REGS[k]);
      chk("reset value", 16'h0000, {8'h00, rdv});
    end
    wr(ADDR_TAP_CONFIG, 8'hFF);
    rd(ADDR_TAP_CONFIG);
    chk("config", 16'h007F, {8'h00, rdv});
    wr(ADDR_THRESHOLD_Z, 8'hFF);
    rd(ADDR_THRESHOLD_Z);
    chk("threshold z", 16'h000F, {8'h00, rdv});
    wr(ADDR_TAP_SOURCE, 8'hFF);
    rd(ADDR_TAP_SOURCE);
    chk("source", 16'h0000, {8'h00, rdv});
    rd(8'h00);
    chk("unmapped", 16'h0000, {8'h00, rdv});
    wr(ADDR_TAP_CONFIG, 8'h00);
    wr(ADDR_IRQ_ROUTE, 8'h3F);
    wr(ADDR_THRESHOLD_XY, 8'h11);
    wr(ADDR_THRESHOLD_Z, 8'h01);
    wr(ADDR_MAX_DURATION, 8'h04);
    wr(ADDR_LATENCY, 8'h02);
    wr(ADDR_WINDOW, 8'h02);
    $display("test regs done");
  endtask

  task automatic t_axes;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TAP_CONFIG, 8'(1 << (2 * i)));
      c0 = irq_cnt;
      tap(i, 15);
      cnt_is("single tap", c0 + 8'h01);
      chk("pin b", 16'h0001, {15'h0000, irq_pin_b_r});
      repeat (60) @(posedge clk);
      chk("hold", 16'h0001, {15'h0000, last_len >= 31 && last_len <= 42});
      tap((i + 1) % 3, 15);
      cnt_is("other axis", c0 + 8'h01);
      repeat (60) @(posedge clk);
    end
    tap(2, 70);
    cnt_is("long tap", c0 + 8'h01);
    $display("test axes done");
  endtask

  task automatic t_latch;
    wr(ADDR_TAP_CONFIG, 8'h41);
    tap(0, 15);
    repeat (100) @(posedge clk);
    chk("latched pin", 16'h0001, {15'h0000, irq_pin_a_r});
    rd(ADDR_TAP_SOURCE);
    chk("source", 16'h0041, {8'h00, rdv});
    repeat (4) @(posedge clk);
    chk("released pin", 16'h0000, {15'h0000, irq_pin_a_r});
    rd(ADDR_TAP_SOURCE);
    chk("source cleared", 16'h0000, {8'h00, rdv});
    $display("test latch done");
  endtask

  task automatic t_double;
    wr(ADDR_TAP_CONFIG, 8'h02);
    c0 = irq_cnt;
    tap(0, 15);
    repeat (5) @(posedge clk);
    tap(0, 8);
    cnt_is("bounce", c0);
    repeat (28) @(posedge clk);
    tap(0, 15);
    cnt_is("double", c0 + 8'h01);
    repeat (120) @(posedge clk);
    tap(0, 15);
    repeat (130) @(posedge clk);
    tap(0, 15);
    cnt_is("late second", c0 + 8'h01);
    repeat (120) @(posedge clk);
    tap(0, 15);
    repeat (50) @(posedge clk);
    tap(0, 70);
    cnt_is("long second", c0 + 8'h01);
    $display("test double done");
  endtask

  // open drain, active low: idle pins released, active pins pulled low
  task automatic t_pins;
    wr(ADDR_IRQ_ROUTE, 8'hFF);
    repeat (2) @(posedge clk);
    chk("idle oe a", 16'h0000, {15'h0000, irq_pin_a_oe_r});
    chk("idle oe b", 16'h0000, {15'h0000, irq_pin_b_oe_r});
    chk("idle wire a", 16'h0001, {15'h0000, pin_a_wire});
    wr(ADDR_TAP_CONFIG, 8'h41);
    tap(0, 15);
    repeat (8) @(posedge clk);
    chk("active oe b", 16'h0001, {15'h0000, irq_pin_b_oe_r});
    chk("active wire a", 16'h0000, {15'h0000, pin_a_wire});
    rd(ADDR_TAP_SOURCE);
    repeat (4) @(posedge clk);
    chk("released wire a", 16'h0001, {15'h0000, pin_a_wire});
    $display("test pins done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // run limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      close_out();
    end
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_axes();
    t_latch();
    t_double();
    t_pins();
    close_out();
  end
endmodule
